// [src/scmc_pkg.sv]
// Constants for the serial channel mode configuration block.
// Assumes a byte-wide register port with a two-bit relative address.
package scmc_pkg;
    // ==========================================================
    // Register port addresses
    localparam logic [1:0] SCMC_ADDR_DATA   = 2'h0;
    localparam logic [1:0] SCMC_ADDR_STATUS = 2'h1;
    localparam logic [1:0] SCMC_ADDR_MODE   = 2'h2;
    localparam logic [1:0] SCMC_ADDR_CTRL   = 2'h3;
    // ==========================================================
    // Reset values
    localparam logic [7:0] SCMC_LFC_RST  = 8'h00;
    localparam logic [7:0] SCMC_CRC_RST  = 8'h00;
    localparam logic [7:0] SCMC_CTRL_RST = 8'h00;
    // ==========================================================
    // Line format field positions
    localparam int SCMC_LF_MODE_LO  = 0;
    localparam int SCMC_LF_LEN_LO   = 2;
    localparam int SCMC_LF_PAR_EN   = 4;
    localparam int SCMC_LF_PAR_EVEN = 5;
    localparam int SCMC_LF_TOP_LO   = 6;
    localparam int SCMC_LF_SYNC_CNT = 7;
    localparam int SCMC_LF_TRANSP   = 6;
    // ==========================================================
    // Clock rate field positions
    localparam int SCMC_CR_RATE_LO = 0;
    localparam int SCMC_CR_RX_INT  = 4;
    localparam int SCMC_CR_TX_INT  = 5;
    // ==========================================================
    // Channel control bit positions
    localparam int SCMC_CT_TX_EN  = 0;
    localparam int SCMC_CT_DTR    = 1;
    localparam int SCMC_CT_RX_EN  = 2;
    localparam int SCMC_CT_BREAK  = 3;
    localparam int SCMC_CT_ERRCLR = 4;
    localparam int SCMC_CT_RTS    = 5;
    localparam int SCMC_CT_OPM_LO = 6;
    // ==========================================================
    // Decoded enumerations
    typedef enum logic [1:0] {
        SCMC_FAC_SYNC1, SCMC_FAC_ASYNC1, SCMC_FAC_ASYNC16, SCMC_FAC_ASYNC64
    } scmc_factor_t;
    typedef enum logic [1:0] {
        SCMC_STOP_INVALID, SCMC_STOP_ONE, SCMC_STOP_ONE_HALF, SCMC_STOP_TWO
    } scmc_stop_t;
    typedef enum logic [1:0] {
        SCMC_OPM_NORMAL, SCMC_OPM_ECHO_STRIP, SCMC_OPM_LOCAL_LOOP, SCMC_OPM_REMOTE_LOOP
    } scmc_opmode_t;
endpackage

// [src/scmc_baud_rom.sv]
// Baud rate lookup for the four-bit rate code.
// Assumes the code is held stable by the register that feeds it.
module scmc_baud_rom (
    // Rate code
    input  wire logic [3:0]  i_code,
    // Decoded rate in tenths of baud
    output logic      [17:0] o_baud_x10
);
    // ==========================================================
    // Lookup table, tenths so that 134.5 stays exact
    always_comb begin
        case (i_code)
            4'h0:    o_baud_x10 = 18'd500;
            4'h1:    o_baud_x10 = 18'd750;
            4'h2:    o_baud_x10 = 18'd1100;
            4'h3:    o_baud_x10 = 18'd1345;
            4'h4:    o_baud_x10 = 18'd1500;
            4'h5:    o_baud_x10 = 18'd3000;
            4'h6:    o_baud_x10 = 18'd6000;
            4'h7:    o_baud_x10 = 18'd12000;
            4'h8:    o_baud_x10 = 18'd18000;
            4'h9:    o_baud_x10 = 18'd20000;
            4'ha:    o_baud_x10 = 18'd24000;
            4'hb:    o_baud_x10 = 18'd36000;
            4'hc:    o_baud_x10 = 18'd48000;
            4'hd:    o_baud_x10 = 18'd72000;
            4'he:    o_baud_x10 = 18'd96000;
            default: o_baud_x10 = 18'd192000;
        endcase
    end
endmodule

// [src/scmc_top.sv]
// Mode and command registers of one serial channel with their decoders.
// Assumes a single-cycle byte access strobe synchronous to i_ref_clk.
//
// Overview of operation
// - Two mode registers share one port, sequenced
// - Low mode bits pick sync/async and factor
// - Length field gives five to eight bits
// - Parity only when enabled; type odd/even
// - Async top bits give stop length
// - Sync top bits give transparency, sync count
// - Rate field decodes to baud rate
// - Separate internal/external transmit and receive clocks
// - Control bits zero and two enable paths
// - RTS and DTR outputs driven inverted
// - Bit three forces break or sends escape
// - Writing bit four clears error flags
// - Top control bits select operating mode
// - Mode registers at port two, readable
// - Control register at port three, readable
module scmc_top
    import scmc_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_n,
    // Register port
    input  wire logic                  i_cs,
    input  wire logic                  i_wr,
    input  wire logic [1:0]            i_addr,
    input  wire logic [7:0]            i_wdata,
    output logic      [7:0]            o_rdata,
    // Line format decode
    output logic                       o_sync_mode,
    output scmc_pkg::scmc_factor_t     o_clk_factor,
    output logic      [3:0]            o_char_bits,
    output logic                       o_parity_en,
    output logic                       o_parity_even,
    output scmc_pkg::scmc_stop_t       o_stop_len,
    output logic                       o_transparent,
    output logic                       o_single_sync,
    // Clock rate decode
    output logic      [3:0]            o_rate_code,
    output logic      [17:0]           o_baud_x10,
    output logic                       o_tx_clk_int,
    output logic                       o_rx_clk_int,
    // Channel control decode
    output logic                       o_tx_enable,
    output logic                       o_rx_enable,
    output logic                       o_rts_n,
    output logic                       o_dtr_n,
    output logic                       o_force_break,
    output logic                       o_send_escape,
    output logic                       o_err_clear,
    output scmc_pkg::scmc_opmode_t     o_op_mode,
    // Sequencer state
    output logic                       o_seq_second
);
    import scmc_pkg::*;

    // ==========================================================
    // Storage
    logic [7:0] line_format_config_ff;   // First mode register
    logic [7:0] clock_rate_config_ff;    // Second mode register
    logic [7:0] channel_control_ff;      // Command byte
    logic       seq_ptr_ff;              // High once line format taken
    logic       err_clear_ff;            // One-cycle clear pulse
    logic       mode_acc;                // Any access to the mode port
    logic       ctrl_wr;                 // Write to the control port
    logic       lf_wr;                   // Write landing in line format
    logic       crc_wr;                  // Write landing in clock rate

    // Sequencer-qualified writes, shared by the checks below
    assign lf_wr  = mode_acc && i_wr && !seq_ptr_ff;
    assign crc_wr = mode_acc && i_wr && seq_ptr_ff;

    assign mode_acc = i_cs && (i_addr == SCMC_ADDR_MODE);
    assign ctrl_wr  = i_cs && i_wr && (i_addr == SCMC_ADDR_CTRL);

    // ==========================================================
    // Mode sequencer: reads advance it too, so read-back walks both bytes
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            seq_ptr_ff <= 1'b0;
        end else if (mode_acc) begin
            seq_ptr_ff <= ~seq_ptr_ff;
        end
    end

    // Line format register; software must load this one first
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            line_format_config_ff <= SCMC_LFC_RST;
        end else if (mode_acc && i_wr && !seq_ptr_ff) begin
            line_format_config_ff <= i_wdata;
        end
    end

    // Clock rate register, second access on the shared port
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            clock_rate_config_ff <= SCMC_CRC_RST;
        end else if (mode_acc && i_wr && seq_ptr_ff) begin
            clock_rate_config_ff <= i_wdata;
        end
    end

    // Channel control; the clear bit is stored and read back like the others, and also fires a pulse
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            channel_control_ff <= SCMC_CTRL_RST;
        end else if (ctrl_wr) begin
            channel_control_ff <= i_wdata;
        end
    end

    // Error clear pulse, only on a write of one
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            err_clear_ff <= 1'b0;
        end else begin
            err_clear_ff <= ctrl_wr && i_wdata[SCMC_CT_ERRCLR];
        end
    end

    // ==========================================================
    // Read data, registered; unmapped ports read zero here
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_cs && !i_wr) begin
            case (i_addr)
                SCMC_ADDR_MODE: begin
                    o_rdata <= seq_ptr_ff ? clock_rate_config_ff
                                          : line_format_config_ff;
                end
                SCMC_ADDR_CTRL: begin
                    o_rdata <= channel_control_ff;
                end
                default: begin
                    o_rdata <= 8'h00;
                end
            endcase
        end
    end

    // ==========================================================
    // Line format decode
    assign o_clk_factor  = scmc_factor_t'(line_format_config_ff[SCMC_LF_MODE_LO +: 2]);
    assign o_sync_mode   = (o_clk_factor == SCMC_FAC_SYNC1);
    assign o_char_bits   = 4'h5 + {2'b00, line_format_config_ff[SCMC_LF_LEN_LO +: 2]};
    assign o_parity_en   = line_format_config_ff[SCMC_LF_PAR_EN];
    // Type is meaningless without enable, so it is gated off
    assign o_parity_even = o_parity_en && line_format_config_ff[SCMC_LF_PAR_EVEN];
    // Stop length only holds in async; sync reports the invalid code
    assign o_stop_len    = o_sync_mode ? SCMC_STOP_INVALID
                         : scmc_stop_t'(line_format_config_ff[SCMC_LF_TOP_LO +: 2]);
    assign o_transparent = o_sync_mode && line_format_config_ff[SCMC_LF_TRANSP];
    assign o_single_sync = o_sync_mode && line_format_config_ff[SCMC_LF_SYNC_CNT];

    // ==========================================================
    // Clock rate decode
    assign o_rate_code  = clock_rate_config_ff[SCMC_CR_RATE_LO +: 4];
    assign o_rx_clk_int = clock_rate_config_ff[SCMC_CR_RX_INT];
    assign o_tx_clk_int = clock_rate_config_ff[SCMC_CR_TX_INT];

    scmc_baud_rom u_baud_rom (
        .i_code     (o_rate_code),
        .o_baud_x10 (o_baud_x10)
    );

    // ==========================================================
    // Channel control decode
    assign o_tx_enable   = channel_control_ff[SCMC_CT_TX_EN];
    assign o_rx_enable   = channel_control_ff[SCMC_CT_RX_EN];
    assign o_rts_n       = ~channel_control_ff[SCMC_CT_RTS];
    assign o_dtr_n       = ~channel_control_ff[SCMC_CT_DTR];
    assign o_force_break = !o_sync_mode && channel_control_ff[SCMC_CT_BREAK];
    assign o_send_escape = o_sync_mode && channel_control_ff[SCMC_CT_BREAK];
    assign o_err_clear   = err_clear_ff;
    assign o_op_mode     = scmc_opmode_t'(channel_control_ff[SCMC_CT_OPM_LO +: 2]);
    assign o_seq_second  = seq_ptr_ff;

    // ==========================================================
    // Checks
    seq_toggle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        mode_acc |=> (seq_ptr_ff != $past(seq_ptr_ff)))
        else $error("mode sequencer did not advance");
    seq_after_rate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (mode_acc && seq_ptr_ff) |=> !seq_ptr_ff)
        else $error("sequencer not back at line format");
    lf_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (mode_acc && i_wr && !seq_ptr_ff) |=> line_format_config_ff == $past(i_wdata))
        else $error("line format write lost");
    cr_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (mode_acc && i_wr && seq_ptr_ff) |=> clock_rate_config_ff == $past(i_wdata))
        else $error("clock rate write lost");
    char_len_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_char_bits == 4'h5 + {2'b00, line_format_config_ff[3:2]})
        else $error("character length wrong");
    rts_dtr_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ctrl_wr |=> (o_rts_n == !$past(i_wdata[5])) && (o_dtr_n == !$past(i_wdata[1])))
        else $error("handshake output wrong");
    enables_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ctrl_wr |=> (o_tx_enable == $past(i_wdata[0])) && (o_rx_enable == $past(i_wdata[2])))
        else $error("enable bit wrong");
    err_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (ctrl_wr && i_wdata[4]) |=> o_err_clear ##1
            (!o_err_clear || $past(ctrl_wr && i_wdata[4])))
        else $error("error clear pulse wrong");
    break_escape_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !(o_force_break && o_send_escape))
        else $error("break and escape together");
    ctrl_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_cs && !i_wr && i_addr == SCMC_ADDR_CTRL) |=> o_rdata == $past(channel_control_ff))
        else $error("control read-back wrong");
    reset_out_a: assert property (@(posedge i_ref_clk)
        !i_rst_n |=> o_rts_n && o_dtr_n && !o_tx_enable && !o_rx_enable)
        else $error("reset state wrong");

    // Mode and factor follow the low bits of the byte just written
    lf_factor_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        lf_wr |=> (o_clk_factor == scmc_factor_t'($past(i_wdata[SCMC_LF_MODE_LO +: 2])))
            && (o_sync_mode == ($past(i_wdata[SCMC_LF_MODE_LO +: 2]) == 2'b00)))
        else $error("mode factor decode wrong");
    // Parity type is reported only while parity is on
    lf_parity_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        lf_wr |=> (o_parity_en == $past(i_wdata[SCMC_LF_PAR_EN]))
            && (o_parity_even == ($past(i_wdata[SCMC_LF_PAR_EN]) && $past(i_wdata[SCMC_LF_PAR_EVEN]))))
        else $error("parity decode wrong");
    // Async byte: top bits become the stop length
    lf_stop_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (lf_wr && i_wdata[SCMC_LF_MODE_LO +: 2] != 2'b00)
            |=> o_stop_len == scmc_stop_t'($past(i_wdata[SCMC_LF_TOP_LO +: 2])))
        else $error("stop length decode wrong");
    // Sync byte: top bits become the two sync controls
    lf_sync_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (lf_wr && i_wdata[SCMC_LF_MODE_LO +: 2] == 2'b00)
            |=> (o_transparent == $past(i_wdata[SCMC_LF_TRANSP]))
            && (o_single_sync == $past(i_wdata[SCMC_LF_SYNC_CNT])))
        else $error("sync control decode wrong");
    // Rate code lands on the second access only
    cr_rate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        crc_wr |=> o_rate_code == $past(i_wdata[SCMC_CR_RATE_LO +: 4]))
        else $error("rate code wrong");
    // Both ends of the rate table
    baud_ends_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ((o_rate_code == 4'h0) -> (o_baud_x10 == 18'd500))
            && ((o_rate_code == 4'hf) -> (o_baud_x10 == 18'd192000)))
        else $error("baud table end wrong");
    // Clock sources are picked independently
    cr_clksel_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        crc_wr |=> (o_tx_clk_int == $past(i_wdata[SCMC_CR_TX_INT]))
            && (o_rx_clk_int == $past(i_wdata[SCMC_CR_RX_INT])))
        else $error("clock select wrong");
    // Bit three means break in async and escape in sync
    break_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ctrl_wr |=> (o_force_break == (!o_sync_mode && $past(i_wdata[SCMC_CT_BREAK])))
            && (o_send_escape == (o_sync_mode && $past(i_wdata[SCMC_CT_BREAK]))))
        else $error("break or escape wrong");
    // Operating mode follows the top command bits
    op_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ctrl_wr |=> o_op_mode == scmc_opmode_t'($past(i_wdata[SCMC_CT_OPM_LO +: 2])))
        else $error("operating mode wrong");
    // No clear pulse without a write of one
    err_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !(ctrl_wr && i_wdata[SCMC_CT_ERRCLR]) |=> !o_err_clear)
        else $error("spurious error clear");
    // Mode read returns the byte the sequencer points at
    mode_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (mode_acc && !i_wr) |=> o_rdata == ($past(seq_ptr_ff) ? $past(clock_rate_config_ff)
                                                               : $past(line_format_config_ff)))
        else $error("mode read-back wrong");
    // Command byte only moves on a control write
    ctrl_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !ctrl_wr |=> $stable(channel_control_ff))
        else $error("command byte changed");
    // Ports outside this block read as zero
    unmapped_rd_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_cs && !i_wr && !i_addr[1]) |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");

    mode_pair_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (mode_acc && i_wr) ##[1:4] (mode_acc && i_wr));
    loop_mode_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        o_op_mode == SCMC_OPM_REMOTE_LOOP);
    err_clear_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_err_clear);
    sync_escape_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_send_escape);
endmodule

// [verif/scmc_term_model.sv]
// Terminal model on the far side of the channel's modem control lines.
// Assumes the lines arrive after level conversion, asserted when low.
module scmc_term_model (
    // Modem control lines from the channel
    input  wire logic i_rts_n,
    input  wire logic i_dtr_n,
    // Terminal view of the lines
    output logic      o_send_req,
    output logic      o_term_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Line decode
    // The terminal keeps no state; an unknown line never counts as asserted
    assign o_send_req   = (i_rts_n === 1'b0);
    assign o_term_ready = (i_dtr_n === 1'b0);
endmodule

// [verif/scmc_top_test.sv]
// Self-checking bench for the serial channel mode and command registers.
// Assumes one strobe per access, with results visible the following cycle.
module scmc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import scmc_pkg::*;
    // ==========================================================
    // Stimulus, driven on the falling edge
    logic         i_ref_clk = 1'b0;
    logic         i_rst_n   = 1'b0;
    logic         i_cs      = 1'b0;
    logic         i_wr      = 1'b0;
    logic [1:0]   i_addr    = 2'h0;
    logic [7:0]   i_wdata   = 8'h00;
    // Design outputs
    logic [7:0]   o_rdata;
    logic         o_sync_mode, o_parity_en, o_parity_even, o_transparent, o_single_sync;
    scmc_factor_t o_clk_factor;
    scmc_stop_t   o_stop_len;
    scmc_opmode_t o_op_mode;
    logic [3:0]   o_char_bits, o_rate_code;
    logic [17:0]  o_baud_x10;
    logic         o_tx_clk_int, o_rx_clk_int, o_tx_enable, o_rx_enable, o_rts_n, o_dtr_n;
    logic         o_force_break, o_send_escape, o_err_clear, o_seq_second;
    logic         t_send_req, t_term_ready;
    // Bookkeeping
    int           cmp_count = 0;
    int           miscompares = 0;
    int           clr_cnt = 0;
    // Expected rates in tenths of baud, indexed by rate code
    logic [17:0]  baud_tab [16] = '{18'h001f4, 18'h002ee, 18'h0044c, 18'h00541, 18'h005dc,
        18'h00bb8, 18'h01770, 18'h02ee0, 18'h04650, 18'h04e20, 18'h05dc0, 18'h08ca0,
        18'h0bb80, 18'h11940, 18'h17700, 18'h2ee00};
    // ==========================================================
    // Design and far-side terminal
    scmc_top dut_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cs(i_cs), .i_wr(i_wr),
        .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_sync_mode(o_sync_mode),
        .o_clk_factor(o_clk_factor), .o_char_bits(o_char_bits), .o_parity_en(o_parity_en),
        .o_parity_even(o_parity_even), .o_stop_len(o_stop_len), .o_transparent(o_transparent),
        .o_single_sync(o_single_sync), .o_rate_code(o_rate_code), .o_baud_x10(o_baud_x10),
        .o_tx_clk_int(o_tx_clk_int), .o_rx_clk_int(o_rx_clk_int), .o_tx_enable(o_tx_enable),
        .o_rx_enable(o_rx_enable), .o_rts_n(o_rts_n), .o_dtr_n(o_dtr_n),
        .o_force_break(o_force_break), .o_send_escape(o_send_escape),
        .o_err_clear(o_err_clear), .o_op_mode(o_op_mode), .o_seq_second(o_seq_second));
    scmc_term_model term_u (.i_rts_n(o_rts_n), .i_dtr_n(o_dtr_n), .o_send_req(t_send_req),
        .o_term_ready(t_term_ready));
    // ==========================================================
    // Clock, error-clear pulse counter and hang guard
    always #4 i_ref_clk = ~i_ref_clk;
    // Counting pulses avoids guessing the exact cycle of the error clear
    always @(posedge i_ref_clk) begin
        if (i_rst_n && o_err_clear === 1'b1) begin
            clr_cnt++;
        end
    end
    initial begin
        repeat (100000) @(posedge i_ref_clk);
        miscompares++;
        summarize();
    end
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One access; the strobe drops for a full cycle so it never toggles twice in a step
    task automatic access(input logic wr, input logic [1:0] addr, input logic [7:0] data);
        i_cs = 1'b1;
        i_wr = wr;
        i_addr = addr;
        i_wdata = data;
        @(negedge i_ref_clk);
        i_cs = 1'b0;
        @(negedge i_ref_clk);
    endtask
    task automatic rd_chk(input logic [1:0] addr, input logic [7:0] exp);
        access(1'b0, addr, 8'h00);
        chk(18'(o_rdata), 18'(exp));
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic reset_scn();
        i_rst_n = 1'b0;
        repeat (12) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        chk(18'({o_rts_n, o_dtr_n, o_tx_enable, o_rx_enable}), 18'h0000c);
        chk(18'(o_seq_second), 18'h0);
        chk(18'(o_sync_mode), 18'h1);
        rd_chk(SCMC_ADDR_CTRL, SCMC_CTRL_RST);
    endtask
    // Every code of every line format field, with a distinct rate each time
    task automatic mode_scn();
        logic [7:0] lf;
        logic [7:0] cr;
        logic       sy;
        for (int k = 0; k < 16; k++) begin
            lf = {k[3:2], k[2], k[0], k[1:0] ^ k[3:2], k[1:0]};
            cr = {2'b00, k[1], k[0], 4'(k)};
            sy = (k[1:0] == 2'b00);
            access(1'b1, SCMC_ADDR_MODE, lf);
            chk(18'(o_seq_second), 18'h1);
            access(1'b1, SCMC_ADDR_MODE, cr);
            chk(18'(o_seq_second), 18'h0);
            chk(18'({o_sync_mode, o_clk_factor}), 18'({sy, lf[1:0]}));
            chk(18'(o_char_bits), 18'(5 + lf[3:2]));
            chk(18'({o_parity_en, o_parity_even}), 18'({lf[4], lf[4] & lf[5]}));
            chk(18'(o_stop_len), sy ? 18'h0 : 18'(lf[7:6]));
            chk(18'({o_transparent, o_single_sync}), 18'({sy & lf[6], sy & lf[7]}));
            chk(o_baud_x10, baud_tab[k]);
            chk(18'(o_rate_code), 18'(k));
            chk(18'({o_tx_clk_int, o_rx_clk_int}), 18'(cr[5:4]));
            rd_chk(SCMC_ADDR_MODE, lf);
            rd_chk(SCMC_ADDR_MODE, cr);
        end
    endtask
    // Walk one command bit at a time, cycling the operating mode field
    task automatic ctrl_scn();
        logic [7:0] c;
        int         n0;
        for (int j = 0; j < 8; j++) begin
            c = (8'h01 << j) | {2'(j), 6'h00};
            n0 = clr_cnt;
            access(1'b1, SCMC_ADDR_CTRL, c);
            @(negedge i_ref_clk);
            chk(18'({o_tx_enable, o_rx_enable}), 18'({c[0], c[2]}));
            chk(18'({o_rts_n, o_dtr_n}), 18'({~c[5], ~c[1]}));
            chk(18'({t_send_req, t_term_ready}), 18'({c[5], c[1]}));
            chk(18'({o_force_break, o_send_escape}), 18'({c[3], 1'b0}));
            chk(18'(clr_cnt - n0), 18'(c[4]));
            chk(18'(o_op_mode), 18'(c[7:6]));
            rd_chk(SCMC_ADDR_CTRL, c);
        end
        access(1'b1, SCMC_ADDR_MODE, 8'h00);
        access(1'b1, SCMC_ADDR_MODE, 8'h00);
        access(1'b1, SCMC_ADDR_CTRL, 8'h08);
        chk(18'({o_force_break, o_send_escape}), 18'h1);
        access(1'b1, SCMC_ADDR_DATA, 8'hff);
        access(1'b1, SCMC_ADDR_STATUS, 8'hff);
        rd_chk(SCMC_ADDR_CTRL, 8'h08);
        rd_chk(SCMC_ADDR_DATA, 8'h00);
        rd_chk(SCMC_ADDR_STATUS, 8'h00);
        chk(18'(o_seq_second), 18'h0);
    endtask
    // ==========================================================
    // Main sequence, ending with a second reset over a live command byte
    initial begin
        @(negedge i_ref_clk);
        reset_scn();
        mode_scn();
        ctrl_scn();
        access(1'b1, SCMC_ADDR_CTRL, 8'hff);
        access(1'b1, SCMC_ADDR_MODE, 8'h4e);
        reset_scn();
        summarize();
    end
endmodule
